// >>> hw/fsth_top.sv
// Purpose: floppy sector transfer handshake, device side
// Assumes: disk pins are asynchronous and pass two flops
// Notes:   prdy is a pin; the register port itself never stalls
`timescale 1ns/1ps
`include "fsth_cfg.svh"

module fsth_top
	import fsth_pkg::*;
(
	// clock, reset, enable
	input  wire logic       clk_in,
	input  wire logic       sys_rst_in,
	input  wire logic       ce_in,
	// register port
	input  wire logic [1:0] addr_in,
	input  wire logic [7:0] wr_data_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic      [7:0] rd_data_out,
	// host bus handshake pins
	output logic            prdy_out,
	output logic      [7:0] bus_data_out,
	output logic            bus_data_oe_out,
	// disk side
	input  wire logic       sector_pulse_in,
	input  wire logic       disk_stb_in,
	input  wire logic [7:0] disk_byte_in,
	output logic            write_gate_out,
	output logic            wr_load_out,
	output logic      [7:0] wr_byte_out,
	output logic            sector_flag_out
);

	localparam logic [11:0] BIT_CYC   = 12'(`FSTH_BIT_CYC);
	localparam logic [11:0] BYTE_CYC  = 12'(`FSTH_BYTE_CYC);
	localparam logic [11:0] SECT_CYC  = 12'(`FSTH_SECT_CYC);
	localparam logic [11:0] SYNC_CYC  = 12'(`FSTH_SYNC_CYC);
	localparam logic [11:0] AVAIL_CYC = 12'(`FSTH_AVAIL_CYC);
	localparam logic [11:0] ONE       = 12'h0001;
	localparam logic [11:0] ZERO      = 12'h0000;

	fsth_state_type state;
	logic       transfer_ready_flag;
	logic [2:0] sp_sync;
	logic [2:0] stb_sync;
	logic [7:0] byte_s1;
	logic [7:0] byte_s2;
	logic       sp_edge;
	logic       stb_edge;
	logic [11:0] byte_cnt;
	logic [7:0]  pre_cnt;
	logic [11:0] sect_cnt;
	logic [11:0] dly_cnt;
	logic [11:0] avail_cnt;
	logic [11:0] prdy_cnt;
	logic [7:0]  rbyte;
	logic [7:0]  wbyte_hold;
	logic        wpend;
	logic        rpend;
	logic        byte_tick;
	logic        data_wr;
	logic        data_rd;
	logic        en_write;
	logic        writing;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// bit 0 is the first flop; edge detect uses bits 1 and 2 only
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			sp_sync  <= 3'h0;
			stb_sync <= 3'h0;
			byte_s1  <= 8'h00;
			byte_s2  <= 8'h00;
		end else if (ce_in) begin
			sp_sync  <= {sp_sync[1:0], sector_pulse_in};
			stb_sync <= {stb_sync[1:0], disk_stb_in};
			byte_s1  <= disk_byte_in;
			byte_s2  <= byte_s1;
		end
	end

	assign sp_edge  = sp_sync[1] & ~sp_sync[2];
	assign stb_edge = stb_sync[1] & ~stb_sync[2];

	// ----------------------------------------
	// access decode
	// ----------------------------------------
	assign writing   = (state == FSTH_PRE) || (state == FSTH_WDATA);
	assign en_write  = wr_in && (addr_in == `FSTH_OFF_CMD)
		&& wr_data_in[`FSTH_BIT_ENWRITE] && !writing;
	// accesses inside the bit time after an ack are ignored
	assign data_wr   = wr_in && (addr_in == `FSTH_OFF_DATA) && transfer_ready_flag
		&& (state == FSTH_WDATA) && (prdy_cnt == ZERO) && !wpend;
	assign data_rd   = rd_in && (addr_in == `FSTH_OFF_DATA) && transfer_ready_flag
		&& (state == FSTH_RDATA) && (prdy_cnt == ZERO) && !rpend;
	assign byte_tick = (byte_cnt == ONE);

	// ----------------------------------------
	// sector flag
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			sect_cnt        <= ZERO;
			sector_flag_out <= 1'b0;
		end else if (ce_in) begin
			if (sp_edge) begin
				sect_cnt        <= SECT_CYC;
				sector_flag_out <= 1'b1;
			end else if (sect_cnt != ZERO) begin
				sect_cnt <= sect_cnt - ONE;
				if (sect_cnt == ONE)
					sector_flag_out <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state     <= FSTH_IDLE;
			transfer_ready_flag <= 1'b0;
			pre_cnt   <= 8'h00;
			rbyte     <= 8'h00;
			dly_cnt   <= ZERO;
		end else if (ce_in) begin
			case (state)
			FSTH_IDLE, FSTH_RWAIT, FSTH_RDATA: begin
				if (en_write) begin
					state     <= FSTH_PRE;
					transfer_ready_flag <= 1'b0;
					pre_cnt   <= `FSTH_PREAMBLE;
				end else if (sp_edge) begin
					state     <= FSTH_RWAIT;
					transfer_ready_flag <= 1'b0;
				end else if (state == FSTH_RWAIT && stb_edge) begin
					// first disk byte is sync: flag now, show it later
					state     <= FSTH_RDATA;
					transfer_ready_flag <= 1'b1;
					rbyte     <= byte_s2;
					dly_cnt   <= SYNC_CYC;
				end else if (state == FSTH_RDATA) begin
					if (stb_edge)
						rbyte <= byte_s2;
					if (dly_cnt != ZERO)
						dly_cnt <= dly_cnt - ONE;
				end
			end
			FSTH_PRE: begin
				if (sp_edge) begin
					state <= FSTH_IDLE;
				end else if (byte_tick) begin
					if (pre_cnt == 8'h01) begin
						state     <= FSTH_WDATA;
						transfer_ready_flag <= 1'b1;
					end
					pre_cnt <= pre_cnt - 8'h01;
				end
			end
			FSTH_WDATA: begin
				if (sp_edge) begin
					state     <= FSTH_IDLE;
					transfer_ready_flag <= 1'b0;
				end
			end
			default: begin
				state     <= FSTH_IDLE;
				transfer_ready_flag <= 1'b0;
			end
			endcase
		end
	end

	// ----------------------------------------
	// read byte window
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			avail_cnt <= ZERO;
		end else if (ce_in) begin
			if (state != FSTH_RDATA)
				avail_cnt <= ZERO;
			else if (dly_cnt == ONE)
				avail_cnt <= AVAIL_CYC;
			else if (stb_edge && dly_cnt == ZERO)
				avail_cnt <= AVAIL_CYC;
			else if (avail_cnt != ZERO)
				avail_cnt <= avail_cnt - ONE;
		end
	end

	// ----------------------------------------
	// write byte timing
	// ----------------------------------------
	// free-running byte clock while the gate is open
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			byte_cnt       <= ZERO;
			write_gate_out <= 1'b0;
			wr_load_out    <= 1'b0;
			wr_byte_out    <= `FSTH_ZERO_BYTE;
		end else if (ce_in) begin
			wr_load_out <= 1'b0;
			if (!writing || sp_edge) begin
				byte_cnt       <= BYTE_CYC;
				write_gate_out <= en_write;
			end else begin
				byte_cnt <= byte_tick ? BYTE_CYC : byte_cnt - ONE;
				if (byte_tick) begin
					wr_load_out <= 1'b1;
					if (state == FSTH_WDATA && wpend)
						wr_byte_out <= wbyte_hold;
					else
						wr_byte_out <= `FSTH_ZERO_BYTE;
				end
			end
		end
	end

	// ----------------------------------------
	// prdy handshake
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			prdy_out        <= 1'b1;
			prdy_cnt        <= ZERO;
			wpend           <= 1'b0;
			rpend           <= 1'b0;
			wbyte_hold      <= 8'h00;
			bus_data_out    <= 8'h00;
			bus_data_oe_out <= 1'b0;
		end else if (ce_in) begin
			if (!transfer_ready_flag) begin
				// transfer over: release a stalled host
				wpend           <= 1'b0;
				rpend           <= 1'b0;
				prdy_out        <= 1'b1;
				prdy_cnt        <= ZERO;
				bus_data_oe_out <= 1'b0;
			end else if (data_wr) begin
				wbyte_hold <= wr_data_in;
				wpend      <= 1'b1;
				prdy_out   <= 1'b0;
			end else if (wpend && byte_tick) begin
				wpend    <= 1'b0;
				prdy_out <= 1'b1;
				prdy_cnt <= BIT_CYC;
			end else if (data_rd) begin
				rpend    <= 1'b1;
				prdy_out <= 1'b0;
			end else if (rpend && avail_cnt != ZERO) begin
				rpend           <= 1'b0;
				bus_data_out    <= rbyte;
				bus_data_oe_out <= 1'b1;
				prdy_out        <= 1'b1;
				prdy_cnt        <= BIT_CYC;
			end else if (prdy_cnt != ZERO) begin
				prdy_cnt <= prdy_cnt - ONE;
				if (prdy_cnt == ONE)
					bus_data_oe_out <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// register read port
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rd_data_out <= 8'h00;
		end else if (ce_in) begin
			rd_data_out <= 8'h00;
			if (rd_in) begin
				case (addr_in)
				`FSTH_OFF_STATUS: begin
					rd_data_out[`FSTH_BIT_XFER]   <= transfer_ready_flag;
					rd_data_out[`FSTH_BIT_SECTOR] <= sector_flag_out;
					rd_data_out[`FSTH_BIT_WRACT]  <= writing;
					rd_data_out[`FSTH_BIT_RDACT]  <= (state == FSTH_RDATA);
				end
				`FSTH_OFF_DATA: begin
					// only meaningful inside the availability window
					rd_data_out <= (avail_cnt != ZERO) ? rbyte : 8'h00;
				end
				default: begin
					rd_data_out <= 8'h00;
				end
				endcase
			end
		end
	end

endmodule : fsth_top

// >>> common/fsth_cfg.svh
// Purpose: constants of the sector transfer handshake block
// Assumes: 125 MHz clock, 4 us disk bit time
// Notes:   counts are derived from times in nanoseconds
//
// Contract
// - enable-write: preamble first, then raise flag
// - write access: prdy low until taken, one bit
// - host stops after checksum: zero fill sector
// - next sector pulse ends write, erase starts
// - read starts without command after sector pulse
// - sync byte shown 25-28 us, held 3-4 us
// - later read bytes every ~25 us, ~3 us
// - read access: prdy low until byte, one bit
// - sector flag 30 us at each sector start
// - transfer_ready_flag in status bit 7
`ifndef FSTH_CFG_SVH
`define FSTH_CFG_SVH

// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define FSTH_OFF_CMD      2'h0
`define FSTH_OFF_STATUS   2'h1
`define FSTH_OFF_DATA     2'h2
`define FSTH_BIT_XFER     7
`define FSTH_BIT_SECTOR   6
`define FSTH_BIT_WRACT    1
`define FSTH_BIT_RDACT    0
`define FSTH_BIT_ENWRITE  0
`define FSTH_ZERO_BYTE    8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define FSTH_CLK_MHZ      125
`define FSTH_BIT_NS       4000
`define FSTH_BYTE_BITS    8
`define FSTH_SECT_NS      30000
`define FSTH_SYNC_DLY_NS  26000
`define FSTH_AVAIL_NS     3500
`define FSTH_PREAMBLE     8'h28
`define FSTH_CYC(ns)      (((ns) * `FSTH_CLK_MHZ + 999) / 1000)
`define FSTH_BIT_CYC      `FSTH_CYC(`FSTH_BIT_NS)
`define FSTH_BYTE_CYC     (`FSTH_BIT_CYC * `FSTH_BYTE_BITS)
`define FSTH_SECT_CYC     `FSTH_CYC(`FSTH_SECT_NS)
`define FSTH_SYNC_CYC     `FSTH_CYC(`FSTH_SYNC_DLY_NS)
`define FSTH_AVAIL_CYC    `FSTH_CYC(`FSTH_AVAIL_NS)

`endif

// >>> common/fsth_pkg.sv
// Purpose: types of the sector transfer handshake block
// Assumes: nothing beyond the cfg header
// Notes:   one-hot state codes
package fsth_pkg;

	typedef enum logic [4:0] {
		FSTH_IDLE  = 5'b0_0001,
		FSTH_PRE   = 5'b0_0010,
		FSTH_WDATA = 5'b0_0100,
		FSTH_RWAIT = 5'b0_1000,
		FSTH_RDATA = 5'b1_0000
	} fsth_state_type;

endpackage : fsth_pkg

// >>> bench/fsth_top_sva.sv
// Purpose: port checks of the sector handshake
// Assumes: ce_in held high
// Notes:   long spans are counted, not repeated
`timescale 1ns/1ps
`include "fsth_cfg.svh"
module fsth_top_sva (
	// clock, reset
	input wire logic       clk_in,
	input wire logic       sys_rst_in,
	// register port
	input wire logic [1:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic       wr_in,
	input wire logic       rd_in,
	input wire logic [7:0] rd_data_out,
	// pins
	input wire logic       prdy_out,
	input wire logic       bus_data_oe_out,
	input wire logic       sector_pulse_in,
	input wire logic       write_gate_out,
	input wire logic       wr_load_out,
	input wire logic       sector_flag_out
);
	int sc, oc, gap, lds;
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	// ----
	// checks
	// ----
	always_ff @(posedge clk_in) sc <= sector_flag_out ? sc + 1 : 0;
	always_ff @(posedge clk_in) oc <= bus_data_oe_out ? oc + 1 : 0;
	always_ff @(posedge clk_in) gap <= wr_load_out ? 1 : gap + 1;
	always_ff @(posedge clk_in) lds <= write_gate_out ? lds + wr_load_out : 0;
	sequence s_edge;
		!sector_pulse_in ##1 sector_pulse_in;
	endsequence
	sequence s_ack;
		$rose(prdy_out) ##0 bus_data_oe_out;
	endsequence
	property p_sect;
		$fell(sector_flag_out) |-> sc == `FSTH_SECT_CYC;
	endproperty
	a_sect: assert property (p_sect) else $error("flag span");
	property p_oe;
		$fell(bus_data_oe_out) |-> oc == `FSTH_BIT_CYC;
	endproperty
	a_oe: assert property (p_oe) else $error("drive span");
	property p_ack;
		$rose(bus_data_oe_out) |-> s_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("no ready");
	property p_stall;
		$fell(prdy_out) |-> $past(rd_in || wr_in)
			&& $past(addr_in) == `FSTH_OFF_DATA;
	endproperty
	a_stall: assert property (p_stall) else $error("stray stall");
	property p_enwr;
		wr_in && addr_in == `FSTH_OFF_CMD && wr_data_in[`FSTH_BIT_ENWRITE]
			|=> write_gate_out;
	endproperty
	a_enwr: assert property (p_enwr) else $error("no gate");
	property p_pre;
		rd_in && addr_in == `FSTH_OFF_STATUS && write_gate_out
			&& lds < `FSTH_PREAMBLE - 1 |=> !rd_data_out[`FSTH_BIT_XFER];
	endproperty
	a_pre: assert property (p_pre) else $error("early flag");
	property p_tick;
		wr_load_out && lds > 0 |-> gap == `FSTH_BYTE_CYC;
	endproperty
	a_tick: assert property (p_tick) else $error("byte tick");
	property p_end;
		s_edge ##0 (write_gate_out && !wr_in) |-> ##[1:8] !write_gate_out;
	endproperty
	a_end: assert property (p_end) else $error("gate kept");
endmodule : fsth_top_sva

bind fsth_top fsth_top_sva u_sva (.clk_in, .sys_rst_in, .addr_in, .wr_data_in,
	.wr_in, .rd_in, .rd_data_out, .prdy_out, .bus_data_oe_out,
	.sector_pulse_in, .write_gate_out, .wr_load_out, .sector_flag_out);

// >>> bench/fsth_host_model.sv
// Purpose: host driver software on the register port
// Assumes: one-cycle strobes set after the edge
// Notes:   released write data shows the inverse
`timescale 1ns/1ps
`include "fsth_cfg.svh"
module fsth_host_model (
	// clock and register port
	input  wire logic       clk_in,
	output logic      [1:0] addr_out,
	output logic      [7:0] wr_data_out,
	output logic            wr_out,
	output logic            rd_out,
	// bus handshake
	input  wire logic       prdy_in,
	input  wire logic [7:0] bus_data_in
);
	initial {addr_out, wr_data_out, wr_out, rd_out} = '0;
	task automatic put(input logic [1:0] a, input logic [7:0] d, input logic w);
		@(posedge clk_in);
		addr_out <= a;
		wr_data_out <= d;
		wr_out <= w;
		rd_out <= !w;
		@(posedge clk_in);
		wr_out <= 1'b0;
		rd_out <= 1'b0;
		wr_data_out <= ~d;
		#1;
	endtask : put
	// one data byte, paced at the safe 6 us loop time
	task automatic give(input logic [7:0] d);
		repeat (`FSTH_CYC(6000)) @(posedge clk_in);
		put(`FSTH_OFF_DATA, d, 1'b1);
	endtask : give
	// retry budget of the driver; a clean disk never spends it
	localparam int RETRY_MAX    = 5;
	localparam int RESTEP_MAX   = 4;
	localparam int RESELECT_MAX = 3;
	// guard first: a quick re-access would be ignored by the device
	task automatic take(output logic [7:0] d);
		repeat (`FSTH_BIT_CYC + 20) @(posedge clk_in);
		put(`FSTH_OFF_DATA, 8'h00, 1'b0);
		for (int n = 0; n < 5000 && prdy_in !== 1'b1; n++)
			@(posedge clk_in) #1;
		d = bus_data_in;
	endtask : take
endmodule : fsth_host_model

// >>> bench/fsth_top_tb.sv
// Purpose: self-checking bench of the sector handshake
// Assumes: ce_in held high
// Notes:   a full write outruns the cycle budget
`timescale 1ns/1ps
`include "fsth_cfg.svh"
module fsth_top_tb;
	logic       clk_in = 0, sys_rst_in = 1, sector_pulse_in = 0;
	logic       disk_stb_in = 0, wr_in, rd_in, prdy_out, bus_data_oe_out;
	logic       write_gate_out, wr_load_out, sector_flag_out;
	logic [7:0] disk_byte_in = 0, rd_data_out, bus_data_out, wr_byte_out;
	logic [7:0] wr_data_in, g[4], h[2], exp_q[$];
	logic [1:0] addr_in;
	int         fails, check_count, cyc, n, t0;
	always #4 clk_in = ~clk_in;
	fsth_top DUT (.clk_in, .sys_rst_in, .ce_in(1'b1), .addr_in, .wr_data_in,
		.wr_in, .rd_in, .rd_data_out, .prdy_out, .bus_data_out,
		.bus_data_oe_out, .sector_pulse_in, .disk_stb_in, .disk_byte_in,
		.write_gate_out, .wr_load_out, .wr_byte_out, .sector_flag_out);
	fsth_host_model host (.clk_in, .addr_out(addr_in),
		.wr_data_out(wr_data_in), .wr_out(wr_in), .rd_out(rd_in),
		.prdy_in(prdy_out), .bus_data_in(bus_data_out));
	task automatic cmp_b(input logic [7:0] v, input logic [7:0] e);
		check_count++;
		if (v !== e) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, v, e);
		end
	endtask : cmp_b
	task automatic cmp_n(input int v, input int e);
		check_count++;
		if (v != e) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, v, e);
		end
	endtask : cmp_n
	task automatic stat(input logic e);
		host.put(`FSTH_OFF_STATUS, 8'h00, 1'b0);
		cmp_b({7'h0, rd_data_out[`FSTH_BIT_XFER]}, {7'h0, e});
	endtask : stat
	task automatic disk(input logic [7:0] b);
		@(posedge clk_in);
		disk_byte_in <= b;
		disk_stb_in <= 1'b1;
		exp_q.push_back(b);
		repeat (6) @(posedge clk_in);
		disk_stb_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		disk_byte_in <= ~b;
	endtask : disk
	task automatic pulse;
		@(posedge clk_in);
		sector_pulse_in <= 1'b1;
		repeat (10) @(posedge clk_in);
		sector_pulse_in <= 1'b0;
	endtask : pulse
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fails++;
			results();
		end
	end
	initial begin
		void'($urandom(32'h7f01));
		repeat (3) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in) #1;
		cmp_b({4'h0, prdy_out, bus_data_oe_out, write_gate_out,
			sector_flag_out}, 8'h08);
		host.put(2'h3, 8'h00, 1'b0);
		cmp_b(rd_data_out, 8'h00);
		$display("reset test done");
		// ----
		// read: no command, sync timing, stall per byte
		// ----
		h[0] = 8'($urandom);
		h[1] = 8'($urandom);
		fork
			begin
				pulse();
				repeat (20) @(posedge clk_in);
				t0 = cyc;
				disk(8'hff);
				repeat (3700) @(posedge clk_in);
				for (int i = 0; i < 3; i++) begin
					disk(i < 2 ? h[i] : h[0] + h[1]);
					repeat (3115) @(posedge clk_in);
				end
			end
			begin
				for (n = 0; n < 500 && rd_data_out[7] !== 1'b1; n++)
					host.put(`FSTH_OFF_STATUS, 8'h00, 1'b0);
				cmp_b({7'h0, rd_data_out[7]}, 8'h01);
				cmp_b(rd_data_out, 8'hc1);
				for (int i = 0; i < 4; i++) begin
					host.take(g[i]);
					cmp_b({6'h0, prdy_out, bus_data_oe_out}, 8'h03);
					cmp_b(g[i], exp_q.pop_front());
					if (i == 0) cmp_n(cyc - t0 inside {[3125:3520]}, 1);
				end
				cmp_b(g[3], g[1] + g[2]);
				cmp_b(g[1], h[0]);
				cmp_b(g[2], h[1]);
			end
		join
		pulse();
		stat(1'b0);
		cmp_b(rd_data_out, 8'h40);
		$display("read test done");
		// ----
		// write: gate, preamble ticks, refused byte, end
		// ----
		for (n = 0; n < 100 && sector_flag_out !== 1'b1; n++)
			@(posedge clk_in) #1;
		cmp_b({7'h0, sector_flag_out}, 8'h01);
		host.put(`FSTH_OFF_CMD, 8'h01, 1'b1);
		cmp_b({7'h0, write_gate_out}, 8'h01);
		host.give(8'($urandom));
		repeat (2) @(posedge clk_in) #1;
		cmp_b({7'h0, prdy_out}, 8'h01);
		for (int i = 0; i < 3; i++) begin
			n = 0;
			do begin
				@(posedge clk_in) #1;
				n++;
			end while (n < 4100 && wr_load_out !== 1'b1);
			cmp_b({7'h0, wr_load_out}, 8'h01);
			cmp_b(wr_byte_out, 8'h00);
			if (i > 0) cmp_n(cyc - t0, `FSTH_BYTE_CYC);
			t0 = cyc;
		end
		stat(1'b0);
		cmp_b(rd_data_out, 8'h02);
		pulse();
		repeat (8) @(posedge clk_in) #1;
		cmp_b({7'h0, write_gate_out}, 8'h00);
		stat(1'b0);
		cmp_b(rd_data_out, 8'h40);
		$display("write test done");
		results();
	end
endmodule : fsth_top_tb
